// >>> verilog/cie_expander.v
`timescale 1ns/1ps
`default_nettype none
`include "cie_map.vh"
module cie_expander #(
  parameter [32*19-1:0] CTRL_TABLE = {(32*19){1'b0}},
  parameter [32*18-1:0] TYPE_TABLE = {(32*18){1'b0}},
  parameter [32*15-1:0] SUB_TABLE  = {(32*15){1'b0}},
  parameter [32*12-1:0] RGN_TABLE  = {(32*12){1'b0}}
) (
  input  wire         mclk,
  input  wire         reset,
  input  wire         fetch_valid,
  input  wire [127:0] fetch_word,
  output wire         native_valid,
  output wire [127:0] native_word,
  output wire         native_was_compact,
  output wire [1:0]   native_ip_units,
  output wire         native_reserved_set
);

  // ****************************************************************
  // Compact field extraction
  // ****************************************************************
  wire [63:0] cw;
  wire        compaction_flag;
  wire [6:0]  opcode_field;
  wire [3:0]  condition_modifier_field;
  wire        accumulator_write_control;
  wire        must_be_zero;
  wire [4:0]  execution_control_index;
  wire [4:0]  operand_type_index;
  wire [4:0]  subregister_index;
  wire [4:0]  src0_region_index;
  wire [4:0]  src1_region_index;
  wire [7:0]  destination_register_number;
  wire [7:0]  source0_register_number;
  wire [7:0]  source1_register_number;

  // Low half is the compact word when the flag is set
  assign cw                          = fetch_word[63:0];
  assign compaction_flag             = fetch_word[`CIE_C_CMPT_BIT]; // [RQ1]
  assign opcode_field                = cw[`CIE_C_OPCODE_HI:0];
  assign condition_modifier_field    = cw[`CIE_C_COND_HI:`CIE_C_COND_LO];
  assign accumulator_write_control   = cw[`CIE_C_ACCWR_BIT];
  assign must_be_zero                = cw[`CIE_C_RSVD_BIT];
  assign execution_control_index     = cw[`CIE_C_CTRLIDX_LO +: 5];
  assign operand_type_index          = cw[`CIE_C_TYPEIDX_LO +: 5];
  assign subregister_index           = cw[`CIE_C_SUBIDX_LO +: 5];
  // Bits 31:30 come from the low dword, 34:32 from the high dword
  assign src0_region_index           = {cw[`CIE_C_SRC0IDX_SPLIT +: 3], cw[`CIE_C_SRC0IDX_LO +: 2]}; // [RQ11]
  assign src1_region_index           = cw[`CIE_C_SRC1IDX_LO +: 5];
  assign destination_register_number = cw[`CIE_C_DSTNUM_LO +: 8];
  assign source0_register_number     = cw[`CIE_C_SRC0NUM_LO +: 8];
  assign source1_register_number     = cw[`CIE_C_SRC1NUM_LO +: 8];

  // ****************************************************************
  // Table lookups
  // ****************************************************************
  wire [18:0] ctrl_val;
  wire [17:0] type_val;
  wire [14:0] sub_val;
  wire [11:0] src0_val;
  wire [11:0] src1_val;

  cie_tables #(
    .CTRL_TABLE (CTRL_TABLE),
    .TYPE_TABLE (TYPE_TABLE),
    .SUB_TABLE  (SUB_TABLE),
    .RGN_TABLE  (RGN_TABLE)
  ) u_tables (
    .ctrl_idx (execution_control_index),
    .type_idx (operand_type_index),
    .sub_idx  (subregister_index),
    .src0_idx (src0_region_index),
    .src1_idx (src1_region_index),
    .ctrl_val (ctrl_val),
    .type_val (type_val),
    .sub_val  (sub_val),
    .src0_val (src0_val),
    .src1_val (src1_val)
  );

  // ****************************************************************
  // Table output fields, MSB first
  // ****************************************************************
  wire [4:0]  sub_src1_bits;
  wire [4:0]  sub_src0_bits;
  wire [4:0]  sub_dst_bits;
  wire [2:0]  type_dst_bits;
  wire [14:0] type_low_bits;
  wire [1:0]  flag_register_bits;
  wire        saturate_bit;
  wire [15:0] ctrl_low_bits;

  // Shared lookups feed several native fields, so slice them once here
  assign sub_src1_bits      = sub_val[14:10];
  assign sub_src0_bits      = sub_val[9:5];
  assign sub_dst_bits       = sub_val[4:0];
  assign type_dst_bits      = type_val[17:15];
  assign type_low_bits      = type_val[14:0];
  assign flag_register_bits = ctrl_val[18:17];
  assign saturate_bit       = ctrl_val[16];
  assign ctrl_low_bits      = ctrl_val[15:0];

  // ****************************************************************
  // Source-1 kind
  // ****************************************************************
  wire [1:0] src1_file;
  wire       src1_is_imm;

  // The file code lands in native 43:42, taken from the looked-up type bits
  assign src1_file   = type_val[`CIE_TYPE_SRC1FILE +: 2];
  assign src1_is_imm = (src1_file == `CIE_FILE_IMMEDIATE); // [RQ19]

  // ****************************************************************
  // Native word assembly
  // ****************************************************************
  reg [127:0] expanded;

  always @*
  begin
    expanded = 128'h0;
    expanded[`CIE_C_OPCODE_HI:0] = opcode_field; // [RQ2]
    expanded[`CIE_C_CMPT_BIT] = compaction_flag;
    expanded[`CIE_N_COND_LO +: 4] = condition_modifier_field; // [RQ3]
    // Reserved compact bit is dropped on purpose, never copied
    expanded[`CIE_N_ACCWR_BIT] = accumulator_write_control; // [RQ5]
    expanded[`CIE_N_SRC0NUM_LO +: 8] = source0_register_number; // [RQ6]
    expanded[`CIE_N_DSTNUM_LO +: 8] = destination_register_number; // [RQ7]
    expanded[`CIE_N_SRC0RGN_LO +: 12] = src0_val; // [RQ10]
    expanded[`CIE_N_SUBSRC1_LO +: 5] = sub_src1_bits; // [RQ12]
    expanded[`CIE_N_SUBSRC0_LO +: 5] = sub_src0_bits; // [RQ12]
    expanded[`CIE_N_SUBDST_LO +: 5] = sub_dst_bits; // [RQ12]
    expanded[`CIE_N_DSTTYPE_LO +: 3] = type_dst_bits; // [RQ13]
    expanded[`CIE_N_TYPES_LO +: 15] = type_low_bits; // [RQ13]
    expanded[`CIE_N_FLAGREG_LO +: 2] = flag_register_bits; // [RQ14]
    expanded[`CIE_N_SATURATE_BIT] = saturate_bit; // [RQ14]
    expanded[`CIE_N_CTRL_LO +: 16] = ctrl_low_bits; // [RQ14]
    if (src1_is_imm)
    begin
      // Immediate low byte overrides the subregister bits at 100:96
      expanded[`CIE_N_IMMLOW_LO +: 8] = source1_register_number; // [RQ15]
      expanded[`CIE_N_IMMIDX_LO +: 5] = src1_region_index; // [RQ9]
      expanded[`CIE_N_SIGNEXT_LO +: 19] = {19{src1_region_index[4]}}; // [RQ9]
    end
    else
    begin
      expanded[`CIE_N_SRC1NUM_LO +: 8] = source1_register_number; // [RQ15]
      expanded[`CIE_N_SRC1RGN_LO +: 12] = src1_val; // [RQ8]
    end
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  reg         valid_q;
  reg [127:0] word_q;
  reg         compact_q;
  reg [1:0]   ip_units_q;
  reg         reserved_q;

  reg         valid_d;
  reg [127:0] word_d;
  reg         compact_d;
  reg [1:0]   ip_units_d;
  reg         reserved_d;

  always @*
  begin
    // No back-pressure; a valid word is taken every cycle
    valid_d    = fetch_valid;
    word_d     = word_q;
    compact_d  = compact_q;
    ip_units_d = ip_units_q;
    reserved_d = reserved_q;
    if (fetch_valid)
    begin
      if (compaction_flag)
      begin
        word_d     = expanded; // [RQ16]
        compact_d  = 1'b1;
        ip_units_d = `CIE_IP_COMPACT; // [RQ18]
        // Flagged only; a set reserved bit is still expanded [RQ4]
        reserved_d = must_be_zero;
      end
      else
      begin
        word_d     = fetch_word; // [RQ20]
        compact_d  = 1'b0;
        ip_units_d = `CIE_IP_NATIVE; // [RQ18]
        reserved_d = 1'b0;
      end
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      valid_q    <= 1'b0;
      word_q     <= 128'h0;
      compact_q  <= 1'b0;
      ip_units_q <= 2'h0;
      reserved_q <= 1'b0;
    end
    else
    begin
      valid_q    <= valid_d;
      word_q     <= word_d;
      compact_q  <= compact_d;
      ip_units_q <= ip_units_d;
      reserved_q <= reserved_d;
    end
  end

  assign native_valid        = valid_q;
  assign native_word         = word_q;
  assign native_was_compact  = compact_q;
  assign native_ip_units     = ip_units_q;
  assign native_reserved_set = reserved_q;

endmodule
`default_nettype wire

// >>> verilog/cie_map.vh
// How it works
// RQ1 - Bit 29 set marks a 64-bit compact word; clear marks a native word.
// RQ2 - Compact opcode bits 6:0 copy straight into native bits 6:0.
// RQ3 - Condition modifier bits 27:24 copy into native bits 27:24 unchanged.
// RQ4 - Software keeps compact bit 28 at zero; it maps to nothing.
// RQ5 - Accumulator write control moves from compact bit 23 to native bit 28.
// RQ6 - Source-0 register number moves from compact 55:48 to native 76:69.
// RQ7 - Destination register number moves from compact 47:40 to native 60:53.
// RQ8 - Register source 1: index 39:35 picks a 12-bit region value for 120:109.
// RQ9 - Immediate source 1: 39:35 go to 108:104, bit 39 fills 127:109.
// RQ10 - Index 34:30 picks a 12-bit source-0 region value for native 88:77.
// RQ11 - Source-0 index is taken across the two 32-bit halves of the word.
// RQ12 - Index 22:18 picks 15 bits spread to native 100:96, 68:64, 52:48.
// RQ13 - Index 17:13 picks 18 bits for native 63:61 and 46:32.
// RQ14 - Index 12:8 picks 19 bits for native 90:89, 31 and 23:8.
// RQ15 - Source-1 number 63:56 goes to 108:101, or 103:96 when immediate.
// RQ16 - Table outputs and direct fields together form the full native word.
// RQ17 - Tools never compact an instruction with three source operands.
// RQ18 - Pointer advances one 64-bit unit for compact, two for native.
// RQ19 - Immediate source 1 is judged from the looked-up source-1 file bits.
// RQ20 - A native word with the flag clear passes through unchanged.
`ifndef CIE_MAP_VH
`define CIE_MAP_VH

// ****************************************************************
// Compact word fields
// ****************************************************************
`define CIE_C_OPCODE_HI     6
`define CIE_C_CMPT_BIT      29
`define CIE_C_RSVD_BIT      28
`define CIE_C_COND_HI       27
`define CIE_C_COND_LO       24
`define CIE_C_ACCWR_BIT     23
`define CIE_C_SUBIDX_LO     18
`define CIE_C_TYPEIDX_LO    13
`define CIE_C_CTRLIDX_LO    8
`define CIE_C_SRC0IDX_LO    30
`define CIE_C_SRC0IDX_SPLIT 32
`define CIE_C_SRC1IDX_LO    35
`define CIE_C_DSTNUM_LO     40
`define CIE_C_SRC0NUM_LO    48
`define CIE_C_SRC1NUM_LO    56

// ****************************************************************
// Native word fields
// ****************************************************************
`define CIE_N_ACCWR_BIT     28
`define CIE_N_SRC0NUM_LO    69
`define CIE_N_DSTNUM_LO     53
`define CIE_N_SRC0RGN_LO    77
`define CIE_N_SRC1RGN_LO    109
`define CIE_N_SRC1NUM_LO    101
`define CIE_N_IMMLOW_LO     96
`define CIE_N_IMMIDX_LO     104
`define CIE_N_SRC1FILE_LO   42
`define CIE_N_COND_LO       24
`define CIE_N_SUBSRC1_LO    96
`define CIE_N_SUBSRC0_LO    64
`define CIE_N_SUBDST_LO     48
`define CIE_N_DSTTYPE_LO    61
`define CIE_N_TYPES_LO      32
`define CIE_N_FLAGREG_LO    89
`define CIE_N_SATURATE_BIT  31
`define CIE_N_CTRL_LO       8
`define CIE_N_SIGNEXT_LO    109

// ****************************************************************
// Codes and counts
// ****************************************************************
`define CIE_FILE_IMMEDIATE  2'h3
`define CIE_TYPE_SRC1FILE   10
`define CIE_IP_COMPACT      2'h1
`define CIE_IP_NATIVE       2'h2

`endif

// >>> verilog/cie_tables.v
`timescale 1ns/1ps
`default_nettype none
module cie_tables #(
  parameter [32*19-1:0] CTRL_TABLE = {(32*19){1'b0}},
  parameter [32*18-1:0] TYPE_TABLE = {(32*18){1'b0}},
  parameter [32*15-1:0] SUB_TABLE  = {(32*15){1'b0}},
  parameter [32*12-1:0] RGN_TABLE  = {(32*12){1'b0}}
) (
  input  wire [4:0]  ctrl_idx,
  input  wire [4:0]  type_idx,
  input  wire [4:0]  sub_idx,
  input  wire [4:0]  src0_idx,
  input  wire [4:0]  src1_idx,
  output wire [18:0] ctrl_val,
  output wire [17:0] type_val,
  output wire [14:0] sub_val,
  output wire [11:0] src0_val,
  output wire [11:0] src1_val
);
  // ****************************************************************
  // Fixed 32-entry lookups; source 0 and 1 share one region table
  // ****************************************************************
  assign ctrl_val = CTRL_TABLE[ctrl_idx*19 +: 19]; // [RQ14]
  assign type_val = TYPE_TABLE[type_idx*18 +: 18]; // [RQ13]
  assign sub_val  = SUB_TABLE[sub_idx*15 +: 15];   // [RQ12]
  assign src0_val = RGN_TABLE[src0_idx*12 +: 12];  // [RQ10]
  assign src1_val = RGN_TABLE[src1_idx*12 +: 12];  // [RQ8]
endmodule
`default_nettype wire

// >>> test/cie_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cie_checker (
  input wire logic         mclk,
  input wire logic         reset,
  input wire logic         fetch_valid,
  input wire logic [127:0] fetch_word,
  input wire logic         native_valid,
  input wire logic [127:0] native_word,
  input wire logic         native_was_compact,
  input wire logic [1:0]   native_ip_units,
  input wire logic         native_reserved_set
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  wire cmp = fetch_valid && fetch_word[29];
  wire imm = native_valid && native_was_compact && native_word[43:42] == 2'b11;
  a_valid_next: assert property (fetch_valid |=> native_valid) else $error("valid missing");
  a_idle_hold: assert property (!fetch_valid |=> !native_valid && $stable(native_word))
    else $error("idle output moved");
  a_opcode_copy: assert property (fetch_valid |=> native_word[6:0] == $past(fetch_word[6:0]))
    else $error("opcode changed");
  a_kind_units: assert property (fetch_valid |=> native_was_compact == $past(fetch_word[29])
    && native_word[29] == native_was_compact && native_ip_units == (native_was_compact ? 2'h1 : 2'h2))
    else $error("kind or units wrong");
  a_cond_accwr: assert property (cmp |=> native_word[28:24] == {$past(fetch_word[23]), $past(fetch_word[27:24])})
    else $error("condition or accumulator bit wrong");
  a_reg_nums: assert property (cmp |=> native_word[76:69] == $past(fetch_word[55:48])
    && native_word[60:53] == $past(fetch_word[47:40])) else $error("register number moved wrong");
  a_native_pass: assert property (fetch_valid && !fetch_word[29] |=> native_word == $past(fetch_word))
    else $error("native word altered");
  a_imm_sign: assert property (imm |-> native_word[127:109] == {19{native_word[108]}})
    else $error("immediate not sign extended");
  a_rsv_flag: assert property (cmp |=> native_reserved_set == $past(fetch_word[28]))
    else $error("reserved flag wrong");
  c_imm: cover property (imm);
  c_reg: cover property (native_valid && native_was_compact && native_word[43:42] != 2'b11);
  c_native: cover property (native_valid && !native_was_compact);
endmodule
bind cie_expander cie_checker i_chk (.mclk(mclk), .reset(reset), .fetch_valid(fetch_valid),
  .fetch_word(fetch_word), .native_valid(native_valid), .native_word(native_word),
  .native_was_compact(native_was_compact), .native_ip_units(native_ip_units),
  .native_reserved_set(native_reserved_set));
`default_nettype wire

// >>> test/cie_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module cie_fetch_model (
  input  wire logic         mclk,
  input  wire logic         load,
  input  wire logic [127:0] word,
  output var  logic         fetch_valid,
  output var  logic [127:0] fetch_word
);
  logic [31:0] fetch_ip;
  initial
  begin
    fetch_valid = 1'b0;
    fetch_word  = '0;
    fetch_ip    = '0;
  end
  // Stale word inverts so the expander cannot lean on held data
  always @(posedge mclk)
  begin
    fetch_valid <= load;
    fetch_word  <= load ? word : ~fetch_word;
    if (load)
      fetch_ip <= fetch_ip + (word[29] ? 32'h1 : 32'h2);
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CK = 'h5b3d7, TK = 'h2c9e3, SK = 'h6a5b, RK = 'h9d3;
  function automatic [18:0] ent(input int w, input int k, input [4:0] i);
    ent = 19'(((i + 1) * k) & ((1 << w) - 1));
  endfunction
  function automatic [607:0] tab(input int w, input int k);
    tab = '0;
    for (int i = 0; i < 32; i++) tab |= {589'h0, ent(w, k, 5'(i))} << (i * w);
  endfunction
  localparam [607:0] CT = tab(19, CK), TT = tab(18, TK), ST = tab(15, SK), RT = tab(12, RK);
  logic mclk = 0, reset = 1, load = 0;
  logic [127:0] word = '0, e;
  logic [127:0] exp_q[$];
  int fail_count = 0, n_checks = 0, ip_sum = 0;
  wire fetch_valid, native_valid, native_was_compact, native_reserved_set;
  wire [127:0] fetch_word, native_word;
  wire [1:0] native_ip_units;
  always #12.5 mclk = ~mclk;
  cie_fetch_model i_fetch (.mclk(mclk), .load(load), .word(word), .fetch_valid(fetch_valid), .fetch_word(fetch_word));
  cie_expander #(.CTRL_TABLE(CT), .TYPE_TABLE(TT[575:0]), .SUB_TABLE(ST[479:0]), .RGN_TABLE(RT[383:0])) i_dut (
    .mclk(mclk), .reset(reset), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .native_valid(native_valid), .native_word(native_word), .native_was_compact(native_was_compact),
    .native_ip_units(native_ip_units), .native_reserved_set(native_reserved_set));
  // ************************************************
  // Expected expansion
  // ************************************************
  function automatic [127:0] expand(input [127:0] c);
    logic [18:0] s, t, k;
    logic [127:0] n;
    if (!c[29]) return c;
    s = ent(15, SK, c[22:18]);
    t = ent(18, TK, c[17:13]);
    k = ent(19, CK, c[12:8]);
    n = '0;
    n[29:0] = {1'b1, c[23], c[27:24], 16'h0, 1'b0, c[6:0]};
    {n[90:89], n[31], n[23:8]} = k;
    {n[63:61], n[46:32]} = t[17:0];
    {n[100:96], n[68:64], n[52:48]} = s[14:0];
    {n[88:77], n[76:69], n[60:53]} = {12'(ent(12, RK, c[34:30])), c[55:48], c[47:40]};
    if (t[11:10] == 2'b11)
      {n[127:109], n[108:104], n[103:96]} = {{19{c[39]}}, c[39:35], c[63:56]};
    else
      {n[120:109], n[108:101]} = {12'(ent(12, RK, c[39:35])), c[63:56]};
    return n;
  endfunction
  function automatic [127:0] rnd();
    logic [127:0] w;
    w = {$urandom, $urandom, $urandom, $urandom};
    w[29] = $urandom % 2;
    if (w[29]) w[6:0] = w[6:0] % 7'h18;
    if (w[29]) w[28] = ($urandom % 8) == 0;
    return w;
  endfunction
  task automatic chk(input [131:0] got, input [131:0] want, input string m);
    n_checks++;
    if (got !== want)
    begin
      fail_count++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, want);
    end
  endtask
  task automatic send(input [127:0] w);
    @(posedge mclk);
    load <= 1'b1;
    word <= w;
    exp_q.push_back(w);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk) load <= 1'b0;
  endtask
  task automatic results();
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge mclk)
    if (!reset && native_valid === 1'b1)
    begin
      ip_sum += native_ip_units;
      e = exp_q.size() ? exp_q.pop_front() : 'x;
      chk({native_word, native_was_compact, native_ip_units, native_reserved_set},
        {expand(e), e[29], e[29] ? 2'h1 : 2'h2, e[29] & e[28]}, "expand");
    end
  initial
  begin
    void'($urandom(80574));
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    send('1);
    send(~128'h2000_0000);
    send(128'h2000_0000);
    send({64'h0, 64'hffff_ffff_efff_ff97});
    send('0);
    repeat (300) if ($urandom % 4) send(rnd()); else idle(1);
    idle(3);
    @(posedge mclk) reset <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk({native_word, native_was_compact, native_ip_units, native_reserved_set}, '0, "reset");
    chk(132'(native_valid), '0, "reset valid");
    @(posedge mclk) reset <= 1'b0;
    repeat (50) send(rnd());
    idle(3);
    chk(132'(exp_q.size()), '0, "left over");
    chk(132'(ip_sum), 132'(i_fetch.fetch_ip), "ip units");
    results();
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    $display("[ERR] %0t timeout", $time);
    results();
  end
endmodule
`default_nettype wire
